// ### itc_pkg.sv
// Shared constants and types for the instruction cycle timing block
package itc_pkg;

    // Widths
    localparam int OPC_W   = 8;
    localparam int LEN_W   = 4;
    localparam int BYTES_W = 2;

    // Timing figures in system clocks
    localparam logic [LEN_W-1:0] MAX_CYCLES     = 4'h8;
    localparam logic [LEN_W-1:0] BRANCH_EXTRA   = 4'h2;
    localparam logic [LEN_W-1:0] CODE_BASE      = 4'h4;
    localparam logic [LEN_W-1:0] CODE_ALIGN_PEN = 4'h1;
    localparam logic [LEN_W-1:0] CODE_SLOW_PEN  = 4'h2;
    localparam logic [LEN_W-1:0] CODE_MAX       = 4'h7;

    // Size of the instruction set the table serves
    localparam int INSTR_COUNT = 109;

    // Reset values
    localparam logic [LEN_W-1:0]   LEN_RST   = 4'h0;
    localparam logic [BYTES_W-1:0] BYTES_RST = 2'h0;

    // Timing class of an opcode
    typedef enum logic [2:0] {
        K_PLAIN,
        K_COND,
        K_CODE,
        K_XRD,
        K_XWR
    } kind_e;

    // One decode table entry
    typedef struct packed {
        logic [BYTES_W-1:0] bytes;
        logic [LEN_W-1:0]   cycles;
        kind_e              kind;
    } instr_s;

    // Memory request raised by an external-data move
    typedef struct packed {
        logic valid;
        logic write;
        logic wide_addr;
        logic to_program;
        logic erase;
    } mem_req_s;

    localparam mem_req_s MEM_REQ_RST = '0;

endpackage

// ### code_read_timing.sv
// Cycle count of a code-byte move from alignment and flash read timing
`timescale 1ns/1ps
module code_read_timing (
    // Conditions of the read
    input  wire logic                     i_misaligned,
    input  wire logic                     i_flash_read_timing,
    // Resulting length
    output logic [itc_pkg::LEN_W-1:0]     o_cycles
);

    logic [itc_pkg::LEN_W-1:0] align_pen;
    logic [itc_pkg::LEN_W-1:0] slow_pen;

    // Penalties add to the fastest aligned read
    assign align_pen = i_misaligned ? itc_pkg::CODE_ALIGN_PEN
                                    : itc_pkg::LEN_RST;
    assign slow_pen  = i_flash_read_timing ? itc_pkg::CODE_SLOW_PEN
                                           : itc_pkg::LEN_RST;
    // Spans four to seven clocks for both base forms
    assign o_cycles  = itc_pkg::CODE_BASE + align_pen + slow_pen;

endmodule

// ### exec_counter.sv
// Down counter that holds an instruction for its length in clocks
`timescale 1ns/1ps
module exec_counter #(
    parameter int CNT_W = itc_pkg::LEN_W
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    // Start of an instruction
    input  wire logic             i_load,
    input  wire logic [CNT_W-1:0] i_length,
    // Progress
    output logic                  o_ready,
    output logic                  o_retire
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             running;

    // Refuse a counter too narrow for the longest stretched instruction
    generate
        if (CNT_W < itc_pkg::LEN_W) begin : g_bad_width
            $error("exec_counter: CNT_W too small");
        end
    endgenerate

    // Counts whole system clocks, no machine-cycle prescale
    assign running  = (cnt_q != '0);
    assign cnt_d    = i_load  ? i_length
                    : running ? cnt_q - CNT_W'(1) : '0;
    // Last cycle may overlap the next load, so one-clock ops go back to back
    assign o_ready  = (cnt_q <= CNT_W'(1));
    assign o_retire = (cnt_q == CNT_W'(1));

    // Count register
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule

// ### instruction_cycle_timing.sv
// Opcode timing decode and execution sequencing for the 8-bit core
`timescale 1ns/1ps
module instruction_cycle_timing (
    // Clock and reset
    input  wire logic                        i_clk,
    input  wire logic                        i_reset_n,
    // Instruction issue
    input  wire logic                        i_issue_valid,
    input  wire logic [itc_pkg::OPC_W-1:0]   i_opcode,
    input  wire logic                        i_branch_taken,
    input  wire logic                        i_code_misaligned,
    // Configuration levels
    input  wire logic                        i_prefetch_enable,
    input  wire logic                        i_flash_read_timing,
    input  wire logic                        i_prog_write_enable,
    input  wire logic                        i_prog_erase_enable,
    // Sequencing
    output logic                             o_ready,
    output logic                             o_retire,
    // Current instruction
    output logic [itc_pkg::LEN_W-1:0]        o_length_q,
    output logic [itc_pkg::BYTES_W-1:0]      o_bytes_q,
    output logic                             o_timing_nominal_q,
    // Memory request of external-data moves
    output itc_pkg::mem_req_s                o_mem_req_q
);

    localparam itc_pkg::kind_e KP = itc_pkg::K_PLAIN;
    localparam itc_pkg::kind_e KC = itc_pkg::K_COND;
    localparam itc_pkg::kind_e KK = itc_pkg::K_CODE;
    localparam itc_pkg::kind_e KR = itc_pkg::K_XRD;
    localparam itc_pkg::kind_e KW = itc_pkg::K_XWR;

    // Build one table entry
    function automatic itc_pkg::instr_s mk(
        input logic [itc_pkg::BYTES_W-1:0] b,
        input logic [itc_pkg::LEN_W-1:0]   c,
        input itc_pkg::kind_e              k
    );
        itc_pkg::instr_s e;
        e.bytes  = b;
        e.cycles = c;
        e.kind   = k;
        return e;
    endfunction

    // Opcode-indexed table; every one of the 256 codes has an entry,
    // cond entries hold the not-taken length
    function automatic itc_pkg::instr_s decode(
        input logic [itc_pkg::OPC_W-1:0] opc
    );
        itc_pkg::instr_s t;
        t = mk(2'h1, 4'h1, KP);
        case (opc[3:0])
            4'h0: begin
                case (opc[7:4])
                    4'h0:                t = mk(2'h1, 4'h1, KP);
                    4'h1, 4'h2, 4'h3:    t = mk(2'h3, 4'h3, KC);
                    4'h4, 4'h5, 4'h6,
                    4'h7:                t = mk(2'h2, 4'h2, KC);
                    4'h8:                t = mk(2'h2, 4'h4, KP);
                    4'h9:                t = mk(2'h3, 4'h3, KP);
                    4'he:                t = mk(2'h1, 4'h3, KR);
                    4'hf:                t = mk(2'h1, 4'h3, KW);
                    default:             t = mk(2'h2, 4'h2, KP);
                endcase
            end
            4'h1: begin
                t = mk(2'h2, 4'h4, KP);
            end
            4'h2: begin
                case (opc[7:4])
                    4'h0, 4'h1:          t = mk(2'h3, 4'h5, KP);
                    4'h2, 4'h3:          t = mk(2'h1, 4'h6, KP);
                    4'he:                t = mk(2'h1, 4'h3, KR);
                    4'hf:                t = mk(2'h1, 4'h3, KW);
                    default:             t = mk(2'h2, 4'h2, KP);
                endcase
            end
            4'h3: begin
                case (opc[7:4])
                    4'h4, 4'h5, 4'h6:    t = mk(2'h3, 4'h3, KP);
                    4'h7:                t = mk(2'h1, 4'h4, KP);
                    4'h8, 4'h9:          t = mk(2'h1, 4'h4, KK);
                    4'he:                t = mk(2'h1, 4'h3, KR);
                    4'hf:                t = mk(2'h1, 4'h3, KW);
                    default:             t = mk(2'h1, 4'h1, KP);
                endcase
            end
            4'h4: begin
                case (opc[7:4])
                    4'h2, 4'h3, 4'h4,
                    4'h5, 4'h6, 4'h7,
                    4'h9:                t = mk(2'h2, 4'h2, KP);
                    4'h8:                t = mk(2'h1, 4'h8, KP);
                    4'ha:                t = mk(2'h1, 4'h4, KP);
                    4'hb:                t = mk(2'h3, 4'h3, KC);
                    default:             t = mk(2'h1, 4'h1, KP);
                endcase
            end
            4'h5: begin
                case (opc[7:4])
                    4'h7, 4'h8:          t = mk(2'h3, 4'h3, KP);
                    4'ha:                t = mk(2'h1, 4'h1, KP);
                    4'hb, 4'hd:          t = mk(2'h3, 4'h3, KC);
                    default:             t = mk(2'h2, 4'h2, KP);
                endcase
            end
            4'h6, 4'h7: begin
                case (opc[7:4])
                    4'h7, 4'h8, 4'ha:    t = mk(2'h2, 4'h2, KP);
                    4'hb:                t = mk(2'h3, 4'h4, KC);
                    default:             t = mk(2'h1, 4'h2, KP);
                endcase
            end
            default: begin
                case (opc[7:4])
                    4'h7, 4'h8, 4'ha:    t = mk(2'h2, 4'h2, KP);
                    4'hb:                t = mk(2'h3, 4'h3, KC);
                    4'hd:                t = mk(2'h2, 4'h2, KC);
                    default:             t = mk(2'h1, 4'h1, KP);
                endcase
            end
        endcase
        return t;
    endfunction

    // Decoded entry of the presented opcode; most lengths equal byte count
    itc_pkg::instr_s            instr;
    logic                       is_cond;
    logic                       is_code;
    logic                       is_xrd;
    logic                       is_xwr;
    logic [itc_pkg::LEN_W-1:0]  code_cycles;
    logic [itc_pkg::LEN_W-1:0]  base_len;
    logic [itc_pkg::LEN_W-1:0]  taken_add;
    logic [itc_pkg::LEN_W-1:0]  fetch_add;
    logic [itc_pkg::LEN_W-1:0]  length;
    logic                       accept;

    assign instr   = decode(i_opcode);
    assign is_cond = (instr.kind == itc_pkg::K_COND);
    assign is_code = (instr.kind == itc_pkg::K_CODE);
    assign is_xrd  = (instr.kind == itc_pkg::K_XRD);
    assign is_xwr  = (instr.kind == itc_pkg::K_XWR);

    // Code-byte moves take their length from the read conditions
    code_read_timing u_code_read_timing (
        .i_misaligned        (i_code_misaligned),
        .i_flash_read_timing (i_flash_read_timing),
        .o_cycles            (code_cycles)
    );

    // Length assembly; the table length is the not-taken figure
    assign base_len  = is_code ? code_cycles : instr.cycles;
    assign taken_add = (is_cond && i_branch_taken) ? itc_pkg::BRANCH_EXTRA
                                                   : itc_pkg::LEN_RST;
    // Without prefetch every program byte costs a fetch clock of its own
    assign fetch_add = i_prefetch_enable ? itc_pkg::LEN_RST
                     : itc_pkg::LEN_W'(instr.bytes);
    assign length    = base_len + taken_add + fetch_add;
    assign accept    = i_issue_valid && o_ready;

    // Holds each instruction for exactly its length
    exec_counter #(
        .CNT_W (itc_pkg::LEN_W)
    ) u_exec_counter (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_load    (accept),
        .i_length  (length),
        .o_ready   (o_ready),
        .o_retire  (o_retire)
    );

    // External-data request; a write can be steered into program flash
    itc_pkg::mem_req_s mem_req_d;
    assign mem_req_d.valid      = accept && (is_xrd || is_xwr);
    assign mem_req_d.write      = is_xwr;
    assign mem_req_d.wide_addr  = ~i_opcode[1];
    assign mem_req_d.to_program = is_xwr && i_prog_write_enable;
    assign mem_req_d.erase      = is_xwr && i_prog_write_enable
                                  && i_prog_erase_enable;

    // Current instruction record, updated on each accept
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_length_q <= itc_pkg::LEN_RST;
            o_bytes_q  <= itc_pkg::BYTES_RST;
        end else if (accept) begin
            o_length_q <= length;
            o_bytes_q  <= instr.bytes;
        end
    end

    // Request lives one clock; nominal flag follows prefetch setting
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_mem_req_q        <= itc_pkg::MEM_REQ_RST;
            o_timing_nominal_q <= 1'b0;
        end else begin
            o_mem_req_q        <= mem_req_d;
            o_timing_nominal_q <= i_prefetch_enable;
        end
    end

endmodule

// ### itc_chk.sv
// Port checker for the instruction cycle timing block
`timescale 1ns/1ps
module itc_chk (
    // Clock and reset
    input wire logic              i_clk,
    input wire logic              i_reset_n,
    // Inputs
    input wire logic              i_issue_valid,
    input wire logic [7:0]        i_opcode,
    input wire logic              i_branch_taken,
    input wire logic              i_prefetch_enable,
    // Outputs
    input wire logic              o_ready,
    input wire logic              o_retire,
    input wire logic [3:0]        o_length_q,
    input wire logic [1:0]        o_bytes_q,
    input wire logic              o_timing_nominal_q,
    input wire itc_pkg::mem_req_s o_mem_req_q
);
    // Accept and nominal-accept strobes
    wire acc = i_issue_valid && o_ready;
    wire nom = acc && i_prefetch_enable;
    logic [3:0] cnt_q;
    // Clocks since accept; saturates so a stuck block cannot wrap
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) cnt_q <= 4'hf;
        else if (acc) cnt_q <= 4'h1;
        else if (cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    chk_retire_count: assert property (o_retire |-> cnt_q == o_length_q)
        else $error("retire out of step with length");
    chk_retire_ready: assert property (o_retire |-> o_ready)
        else $error("retire without ready");
    chk_max_len: assert property (nom |=> o_length_q <= 4'h8)
        else $error("length above eight");
    chk_bank_op: assert property (nom && i_opcode[7:3] == 5'h05
        |=> o_length_q == 4'h1 && o_bytes_q == 2'h1)
        else $error("bank op timing");
    chk_branch_len: assert property (nom && i_opcode == 8'h40
        |=> o_length_q == ($past(i_branch_taken) ? 4'h4 : 4'h2))
        else $error("branch timing");
    chk_code_range: assert property (nom
        && (i_opcode == 8'h83 || i_opcode == 8'h93)
        |=> o_length_q inside {[4'h4:4'h7]})
        else $error("code move out of range");
    chk_ext_req: assert property (acc && i_opcode == 8'hf0 |=> o_mem_req_q.valid
        && o_mem_req_q.write && o_mem_req_q.wide_addr ##1 !o_mem_req_q.valid)
        else $error("ext move request");
    chk_prog_route: assert property (o_mem_req_q.valid && o_mem_req_q.erase
        |-> o_mem_req_q.to_program && o_mem_req_q.write)
        else $error("erase not routed to program");
    chk_busy_hold: assert property (nom && i_opcode == 8'h84
        |=> (!o_ready) [*7] ##1 (o_ready && o_retire))
        else $error("long op busy window");
    chk_nominal_off: assert property (acc && !i_prefetch_enable
        && i_opcode == 8'h24 |=> !o_timing_nominal_q && o_length_q == 4'h4)
        else $error("prefetch off timing");
endmodule
bind instruction_cycle_timing itc_chk u_itc_chk (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_issue_valid(i_issue_valid),
    .i_opcode(i_opcode), .i_branch_taken(i_branch_taken),
    .i_prefetch_enable(i_prefetch_enable), .o_ready(o_ready),
    .o_retire(o_retire), .o_length_q(o_length_q), .o_bytes_q(o_bytes_q),
    .o_timing_nominal_q(o_timing_nominal_q), .o_mem_req_q(o_mem_req_q));

// ### mem_model.sv
// Far-side memory model tallying external-data traffic
`timescale 1ns/1ps
module mem_model (
    // Clock and request
    input  wire logic              i_clk,
    input  wire itc_pkg::mem_req_s i_req,
    // Traffic tallies
    output logic [7:0]             o_reads,
    output logic [7:0]             o_writes,
    output logic [7:0]             o_prog,
    output logic [7:0]             o_erases
);
    initial {o_reads, o_writes, o_prog, o_erases} = 32'h0;
    // Sort each valid request; fields mean nothing without valid
    always @(posedge i_clk) begin
        if (i_req.valid === 1'h1) begin
            if (i_req.write) o_writes <= o_writes + 8'h1;
            else o_reads <= o_reads + 8'h1;
            if (i_req.to_program) o_prog <= o_prog + 8'h1;
            if (i_req.erase) o_erases <= o_erases + 8'h1;
        end
    end
endmodule

// ### tb_top.sv
// Self-checking bench for the instruction cycle timing block
`timescale 1ns/1ps
module tb_top;
    // Row: opcode, flags {taken,misal,slow,prefetch_enable,pw,pe}, clocks, bytes
    typedef struct packed {
        logic [7:0] opc;
        logic [7:0] flg;
        logic [3:0] len;
        logic [3:0] byt;
    } row_s;
    logic [23:0] rows [38] = '{24'h280411, 24'h260421, 24'h240422,
        24'h250422, 24'h530433, 24'h430433, 24'h630433, 24'he40411,
        24'hf40411, 24'h230411, 24'h330411, 24'h030411, 24'h130411,
        24'hc40411, 24'he00431, 24'he20431, 24'he30431, 24'hf20631,
        24'hf00731, 24'hf30431, 24'h900433, 24'h850433, 24'h750433,
        24'hf60421, 24'h860422, 24'ha60422, 24'h780422, 24'hc00422,
        24'h930441, 24'h931c71, 24'h831451, 24'h830c61, 24'h400422,
        24'h402442, 24'hb62463, 24'h840481, 24'h240042, 24'ha50411};
    logic i_clk, i_reset_n, valid, taken, misal, slow, prefetch_enable, pw, pe;
    logic [7:0] opc;
    logic ready, retire, nominal;
    logic [3:0] length;
    logic [1:0] bytes;
    logic [7:0] rd, wr, pg, er;
    itc_pkg::mem_req_s mreq;
    int num_errors = 0;
    int checks = 0;

    instruction_cycle_timing u_instruction_cycle_timing (.i_clk(i_clk),
        .i_reset_n(i_reset_n), .i_issue_valid(valid), .i_opcode(opc),
        .i_branch_taken(taken), .i_code_misaligned(misal),
        .i_prefetch_enable(prefetch_enable), .i_flash_read_timing(slow),
        .i_prog_write_enable(pw), .i_prog_erase_enable(pe),
        .o_ready(ready), .o_retire(retire), .o_length_q(length),
        .o_bytes_q(bytes), .o_timing_nominal_q(nominal),
        .o_mem_req_q(mreq));
    mem_model u_mem_model (.i_clk(i_clk), .i_req(mreq), .o_reads(rd),
        .o_writes(wr), .o_prog(pg), .o_erases(er));

    // 125 MHz system clock
    initial begin
        i_clk = 1'h0;
        forever #4 i_clk = ~i_clk;
    end

    task automatic cmp(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic test_done;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Issue one row, then count clocks to its retire pulse
    task automatic run(input row_s r);
        int n;
        @(negedge i_clk);
        opc = r.opc;
        {taken, misal, slow, prefetch_enable, pw, pe} = r.flg[5:0];
        valid = 1'h1;
        @(negedge i_clk);
        valid = 1'h0;
        cmp("length", {4'h0, r.len}, {4'h0, length});
        cmp("bytes", {4'h0, r.byt}, {6'h0, bytes});
        cmp("nominal", {7'h0, prefetch_enable}, {7'h0, nominal});
        if (r.opc inside {8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3})
            cmp("mem_req", {4'h1, r.opc[4], r.opc[1:0] == 2'h0,
                r.opc[4] & pw, r.opc[4] & pw & pe}, {3'h0, mreq});
        else cmp("mem_valid", 8'h0, {7'h0, mreq.valid});
        n = 1;
        while (retire !== 1'h1 && n < 12) begin
            @(negedge i_clk);
            n++;
        end
        cmp("clocks", {4'h0, r.len}, n[7:0]);
        if (n >= 12) test_done;
    endtask

    initial begin
        {i_reset_n, valid, opc, taken, misal, slow, prefetch_enable, pw, pe} = 16'h0;
        prefetch_enable = 1'h1;
        repeat (20) @(negedge i_clk);
        cmp("rst_state", 8'h80, {ready, retire, length, bytes});
        cmp("rst_mem", 8'h0, {2'h0, nominal, mreq});
        i_reset_n = 1'h1;
        $display("reset test done");
        for (int i = 0; i < 38; i++) run(rows[i]);
        $display("table test done");
        // One-clock ops accepted on every edge
        @(negedge i_clk);
        opc = 8'h28;
        valid = 1'h1;
        repeat (3) begin
            @(negedge i_clk);
            cmp("b2b_retire", 8'h1, {7'h0, retire});
        end
        valid = 1'h0;
        $display("back to back test done");
        // Request held while busy waits for the retire edge
        @(negedge i_clk);
        opc = 8'h84;
        valid = 1'h1;
        @(negedge i_clk);
        opc = 8'h24;
        for (int k = 1; k <= 8; k++) begin
            cmp("busy_len", 8'h8, {4'h0, length});
            cmp("busy_retire", {7'h0, k == 8}, {7'h0, retire});
            @(negedge i_clk);
        end
        valid = 1'h0;
        cmp("next_len", 8'h2, {4'h0, length});
        $display("busy test done");
        // Reset in mid instruction drops it
        @(negedge i_clk);
        opc = 8'h84;
        valid = 1'h1;
        @(negedge i_clk);
        valid = 1'h0;
        i_reset_n = 1'h0;
        @(negedge i_clk);
        cmp("mid_rst", 8'h80, {ready, retire, length, bytes});
        i_reset_n = 1'h1;
        repeat (9) @(negedge i_clk);
        cmp("mid_rst_quiet", 8'h0, {7'h0, retire});
        cmp("external_data_space_reads", 8'h3, rd);
        cmp("external_data_space_writes", 8'h3, wr);
        cmp("prog_writes", 8'h2, pg);
        cmp("prog_erases", 8'h1, er);
        $display("reset and traffic test done");
        test_done;
    end
endmodule
